// ==== pkg/cem_pkg.sv ====
// Shared constants and carriers for the CPU event monitor counters.
// Assumes a 32-bit AXI4-Lite register port and a 25 MHz core clock.
package cem_pkg;

	// ----------------------------------------------------------------
	// Geometry and timing
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W = 16;
	localparam int unsigned PAIRS = 2;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned CLK_NS = 40;
	localparam int unsigned US_NS = 1000;
	localparam int unsigned US_CYCLES = US_NS / CLK_NS;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_EVSEL = 8'h04;
	localparam logic [7:0] OFS_FUNC = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_DISP_A = 8'h14;
	localparam logic [7:0] OFS_DISP_B = 8'h18;

	// ----------------------------------------------------------------
	// Counter control channel fields
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_CNT_A = 6;
	localparam int unsigned CTRL_DISP_MODE = 8;
	localparam int unsigned CTRL_STOP_A = 9;
	localparam int unsigned CTRL_CARRY_BASE = 11;
	localparam int unsigned CTRL_PAIR_SEL = 15;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Gate enables, commands, status bits
	// ----------------------------------------------------------------
	localparam int unsigned G_SEL_JOBS = 0;
	localparam int unsigned G_ALL_JOBS = 1;
	localparam int unsigned G_MONITOR = 2;
	localparam int unsigned G_DF56 = 3;
	localparam int unsigned G_DF57 = 4;
	localparam int unsigned CMD_RESTART = 3;
	localparam int unsigned CMD_CLR_FAULT = 7;
	localparam int unsigned ST_FAULT_BASE = 0;
	localparam int unsigned ST_HALTED = 3;
	localparam int unsigned ST_EV_STOP = 4;
	localparam int unsigned ST_ENV = 8;
	localparam int unsigned ST_MAINS = 9;
	localparam int unsigned ST_SECTION = 10;

	// ----------------------------------------------------------------
	// Event codes
	// ----------------------------------------------------------------
	localparam logic [7:0] EV_FUNC = 8'h12;
	localparam logic [7:0] EV_TIME = 8'h12;
	localparam logic [7:0] EV_MON = 8'h13;
	localparam logic [7:0] EV_STALL = 8'h13;
	localparam logic [1:0] MON_MATCH = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [4:0] gates;
		logic [7:0] ev_second;
		logic [7:0] ev_first;
	} cem_pair_cfg_s;

	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] code;
	} cem_func_s;

	typedef struct packed {
		logic df57;
		logic df56;
		logic job_en;
		logic monitor;
	} cem_cpu_s;

endpackage : cem_pkg

// ==== src/cem_pair.sv ====
// One pair of 16-bit event counters with optional carry chaining.
// Assumes increments arrive already gated and selected by the parent.
`timescale 1ns/1ps
module cem_pair import cem_pkg::*; #(
	parameter int unsigned W = CNT_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic inc_first,
	input wire logic inc_second,
	input wire logic carry_into_first,
	input wire logic carry_into_second,
	input wire logic clr_all,
	input wire logic clr_top,
	output logic [W-1:0] cnt_first,
	output logic [W-1:0] cnt_second,
	output logic any_inc
);
	if (W < 2) begin : g_bad_width
		$error("cem_pair: width below 2");
	end

	logic [W-1:0] first_reg, first_next, second_reg, second_next;
	logic wrap_f, wrap_s, step_f, step_s, low_is_first, low_is_second;

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	always_comb begin
		wrap_f = inc_first && (first_reg == '1);
		wrap_s = inc_second && (second_reg == '1);
		step_f = inc_first | (wrap_s & carry_into_first);
		step_s = inc_second | (wrap_f & carry_into_second);
		low_is_first = carry_into_second & ~carry_into_first;
		low_is_second = carry_into_first & ~carry_into_second;
		first_next = first_reg;
		second_next = second_reg;
		// Only the top bit of the whole count is cleared, so a chained low half keeps it
		if (clr_all) begin
			first_next = '0;
			second_next = '0;
		end else if (clr_top) begin
			if (!low_is_first) first_next[W-1] = 1'b0;
			if (!low_is_second) second_next[W-1] = 1'b0;
		end
		first_next = first_next + W'(step_f);
		second_next = second_next + W'(step_s);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			first_reg <= '0;
			second_reg <= '0;
		end else begin
			first_reg <= first_next;
			second_reg <= second_next;
		end
	end

	assign cnt_first = first_reg;
	assign cnt_second = second_reg;
	assign any_inc = step_f | step_s;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_carry_chain: assert property (inc_first && first_reg == '1 && low_is_first && !inc_second && !clr_all && !clr_top
		|=> second_reg == W'($past(second_reg) + 1'b1)) else $error("high half missed carry");
	a_wrap_silent: assert property (inc_first && first_reg == '1 && !carry_into_first && !clr_all && !clr_top
		|=> first_reg == '0) else $error("unchained wrap wrong");
	a_split_halves: assert property (!carry_into_first && !carry_into_second && !inc_second && !clr_all && !clr_top
		|=> $stable(second_reg)) else $error("unchained partner moved");
	c_chain_wrap: cover property (wrap_f && carry_into_second);

endmodule : cem_pair

// ==== src/cem_counters.sv ====
// CPU event monitor counters: two counter pairs, gating, stop and fault halt.
// Assumes an AXI4-Lite master and CPU event lines synchronous to CLK.
`timescale 1ns/1ps
module cem_counters import cem_pkg::*; #(
	parameter int unsigned US_CYCLES_P = US_CYCLES
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic INSTR_ISSUE,
	input wire logic [7:0] FUNC_CODE,
	input wire logic [1:0] MON_FIELD,
	input wire logic FU_NO_OUTPUT,
	input wire logic FU_ALL_REQUESTED,
	input wire logic FU_SETUP_SHUTDOWN,
	input wire cem_cpu_s CPU_LINES,
	input wire logic INSTR_BOUNDARY,
	input wire logic [2:0] FAULT_IN,
	input wire logic ENV_ALARM,
	input wire logic MAINS_FAIL,
	input wire logic SECTION_FAIL,
	output logic CPU_HALT
);
	if (US_CYCLES_P < 2 || US_CYCLES_P > 31) begin : g_bad_us
		$error("cem_counters: microsecond divider out of range");
	end

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction : wmerge

	// ----------------------------------------------------------------
	// Register file and bus slave
	// ----------------------------------------------------------------
	logic [15:0] ctrl_reg, ctrl_next;
	cem_pair_cfg_s cfg_reg [PAIRS];
	cem_pair_cfg_s cfg_next [PAIRS];
	cem_func_s func_reg, func_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_take, rd_take, clear_fault, restart;
	logic [7:0] waddr, raddr;
	logic [PAIRS-1:0] clr_all, clr_top, any_inc;
	logic [CNT_W-1:0] cnt_f [PAIRS];
	logic [CNT_W-1:0] cnt_s [PAIRS];
	logic [2:0] fault_reg, fault_next;
	logic evstop_reg, evstop_next, halt_reg, halt_next, stop_hit;
	logic [4:0] us_reg, us_next;
	logic us_tick, func_match, stall;
	logic [PAIRS-1:0] gate_ok, cnt_en, ev_first, ev_second;
	logic [31:0] status_word;
	int unsigned pw;

	assign wr_take = AWVALID & WVALID & ~bvalid_reg;
	assign rd_take = ARVALID & ~rvalid_reg;
	assign AWREADY = wr_take;
	assign WREADY = wr_take;
	assign ARREADY = rd_take;
	assign waddr = {AWADDR[7:2], 2'b00};
	assign raddr = {ARADDR[7:2], 2'b00};
	assign pw = ctrl_reg[CTRL_PAIR_SEL] ? 1 : 0;
	assign status_word = {21'h0, SECTION_FAIL, MAINS_FAIL, ENV_ALARM, 3'h0, evstop_reg, halt_reg, fault_reg};

	always_comb begin
		ctrl_next = ctrl_reg;
		cfg_next = cfg_reg;
		func_next = func_reg;
		bvalid_next = bvalid_reg & ~BREADY;
		bresp_next = bresp_reg;
		clear_fault = 1'b0;
		restart = 1'b0;
		if (wr_take) begin
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			unique case (waddr)
				OFS_CTRL: ctrl_next = 16'(wmerge({16'h0, ctrl_reg}, WDATA, WSTRB));
				OFS_EVSEL: cfg_next[pw] = 21'(wmerge({11'h0, cfg_reg[pw]}, WDATA, WSTRB));
				OFS_FUNC: func_next = 16'(wmerge({16'h0, func_reg}, WDATA, WSTRB));
				OFS_CMD: begin
					clear_fault = WSTRB[0] & WDATA[CMD_CLR_FAULT];
					restart = WSTRB[0] & WDATA[CMD_RESTART];
				end
				OFS_STATUS, OFS_DISP_A, OFS_DISP_B: bresp_next = RESP_OKAY;
				default: bresp_next = RESP_SLVERR;
			endcase
		end
	end

	// Counters are sampled into the read word before the clear lands
	always_comb begin
		rvalid_next = rvalid_reg & ~RREADY;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		clr_all = '0;
		clr_top = '0;
		if (rd_take) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = 32'h0;
			unique case (raddr)
				OFS_CTRL: rdata_next = {16'h0, ctrl_reg};
				OFS_EVSEL: rdata_next = {11'h0, cfg_reg[pw]};
				OFS_FUNC: rdata_next = {16'h0, func_reg};
				OFS_CMD: rdata_next = 32'h0;
				OFS_STATUS: rdata_next = status_word;
				OFS_DISP_A, OFS_DISP_B: begin
					rdata_next = (raddr == OFS_DISP_A) ? {cnt_s[0], cnt_f[0]} : {cnt_s[1], cnt_f[1]};
					clr_all[raddr == OFS_DISP_B] = ~ctrl_reg[CTRL_DISP_MODE];
					clr_top[raddr == OFS_DISP_B] = ctrl_reg[CTRL_DISP_MODE];
				end
				default: rresp_next = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_reg <= CTRL_RESET;
			cfg_reg <= '{default: '0};
			func_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			cfg_reg <= cfg_next;
			func_reg <= func_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	assign BVALID = bvalid_reg;
	assign BRESP = bresp_reg;
	assign RVALID = rvalid_reg;
	assign RRESP = rresp_reg;
	assign RDATA = rdata_reg;

	// ----------------------------------------------------------------
	// Event selection and gating
	// ----------------------------------------------------------------
	always_comb begin
		us_tick = (us_reg == 5'(US_CYCLES_P - 1));
		us_next = us_tick ? 5'h0 : us_reg + 5'h1;
		func_match = INSTR_ISSUE && (((FUNC_CODE ^ func_reg.code) & func_reg.mask) == 8'h0);
		// Setup and shutdown cycles are flagged by the unit and never count as stalls
		stall = FU_NO_OUTPUT & FU_ALL_REQUESTED & ~FU_SETUP_SHUTDOWN;
	end

	for (genvar p = 0; p < PAIRS; p++) begin : g_pair
		always_comb begin
			gate_ok[p] = (cfg_reg[p].gates[G_SEL_JOBS] & CPU_LINES.job_en & ~CPU_LINES.monitor)
				| (cfg_reg[p].gates[G_ALL_JOBS] & ~CPU_LINES.monitor)
				| (cfg_reg[p].gates[G_MONITOR] & CPU_LINES.monitor)
				| (((cfg_reg[p].gates[G_DF56] & CPU_LINES.df56) | (cfg_reg[p].gates[G_DF57] & CPU_LINES.df57))
					& (CPU_LINES.monitor | CPU_LINES.job_en));
			cnt_en[p] = ctrl_reg[CTRL_CNT_A + p] & gate_ok[p];
			ev_first[p] = ((cfg_reg[p].ev_first == EV_FUNC) & func_match)
				| ((cfg_reg[p].ev_first == EV_MON) & (MON_FIELD == MON_MATCH));
			ev_second[p] = ((cfg_reg[p].ev_second == EV_TIME) & us_tick)
				| ((cfg_reg[p].ev_second == EV_STALL) & stall);
		end

		cem_pair #(.W(CNT_W)) u_pair (
			.clk(CLK),
			.rst_n(RST_N),
			.inc_first(ev_first[p] & cnt_en[p]),
			.inc_second(ev_second[p] & cnt_en[p]),
			.carry_into_first(ctrl_reg[CTRL_CARRY_BASE + 2*p]),
			.carry_into_second(ctrl_reg[CTRL_CARRY_BASE + 2*p + 1]),
			.clr_all(clr_all[p]),
			.clr_top(clr_top[p]),
			.cnt_first(cnt_f[p]),
			.cnt_second(cnt_s[p]),
			.any_inc(any_inc[p])
		);
	end

	// ----------------------------------------------------------------
	// Event stop, logic faults, restart
	// ----------------------------------------------------------------
	always_comb begin
		stop_hit = |(any_inc & ctrl_reg[CTRL_STOP_A +: PAIRS]);
		// New events win over a clear arriving in the same cycle
		fault_next = (fault_reg & ~{3{clear_fault}}) | FAULT_IN;
		evstop_next = (evstop_reg & ~clear_fault) | stop_hit;
		halt_next = halt_reg;
		if (stop_hit || ((|fault_next) && INSTR_BOUNDARY)) begin
			halt_next = 1'b1;
		end else if (restart && fault_next == 3'h0 && !evstop_next) begin
			halt_next = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			fault_reg <= 3'h0;
			evstop_reg <= 1'b0;
			halt_reg <= 1'b0;
			us_reg <= 5'h0;
		end else begin
			fault_reg <= fault_next;
			evstop_reg <= evstop_next;
			halt_reg <= halt_next;
			us_reg <= us_next;
		end
	end

	assign CPU_HALT = halt_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_func_count: assert property (cnt_en[0] && cfg_reg[0].ev_first == EV_FUNC && func_match && !clr_all[0]
		&& !clr_top[0] |=> cnt_f[0] != $past(cnt_f[0])) else $error("function match not counted");
	a_mask_zero: assert property (cnt_en[0] && cfg_reg[0].ev_first == EV_FUNC && func_reg.mask == 8'h0
		&& INSTR_ISSUE && !clr_all[0] && !clr_top[0] |=> cnt_f[0] != $past(cnt_f[0])) else $error("zero mask missed");
	a_time_base: assert property (cnt_en[1] && cfg_reg[1].ev_second == EV_TIME && us_tick && !clr_all[1]
		&& !clr_top[1] |=> cnt_s[1] != $past(cnt_s[1])) else $error("microsecond not counted");
	a_idle_hold: assert property (!ctrl_reg[CTRL_CNT_A] && !clr_all[0] && !clr_top[0]
		|=> $stable(cnt_f[0]) && $stable(cnt_s[0])) else $error("count without count line");
	a_stop_halt: assert property ((ctrl_reg[CTRL_STOP_A] && any_inc[0])
		|| (ctrl_reg[CTRL_STOP_A + 1] && any_inc[1]) |=> halt_reg && status_word[ST_EV_STOP])
		else $error("event stop missed");
	a_fault_halt: assert property ((|FAULT_IN) && INSTR_BOUNDARY
		|=> CPU_HALT && fault_reg != 3'h0 ##1 fault_reg != 3'h0 || $past(clear_fault)) else $error("fault halt missed");
	c_func_count: cover property (cnt_en[0] && ev_first[0]);
	c_event_stop: cover property (stop_hit ##[1:50] restart);
	c_display_read: cover property (|clr_all);

endmodule : cem_counters

// ==== test/cem_mcu_model.sv ====
// Bus-master model of the maintenance controller on the AXI4-Lite register port.
// Assumes the bench calls wr and rd hierarchically and one clock domain.
`timescale 1ns/1ps
module cem_mcu_model import cem_pkg::*; (
	input wire logic clk,
	output logic [ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
	end

	// ----------------------------------------------------------------
	// Transfers
	// ----------------------------------------------------------------
	// Released payloads are inverted so a stale value is never mistaken for a fresh one
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad;
		logic wd;
		@(posedge clk);
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awready && !ad) begin
				ad = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wready && !wd) begin
				wd = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		do @(posedge clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : cem_mcu_model

// ==== test/cem_counters_tb_top.sv ====
// Self-checking bench for the event monitor counters.
// Assumes the controller model drives the register port; CPU lines come from here.
`timescale 1ns/1ps
module cem_counters_tb_top import cem_pkg::*;;
	logic CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
	logic [ADDR_W-1:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, d;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, MON_FIELD, r;
	logic INSTR_ISSUE, FU_NO_OUTPUT, FU_ALL_REQUESTED, FU_SETUP_SHUTDOWN, INSTR_BOUNDARY;
	logic ENV_ALARM, MAINS_FAIL, SECTION_FAIL, CPU_HALT;
	logic [7:0] FUNC_CODE;
	logic [2:0] FAULT_IN;
	cem_cpu_s CPU_LINES;
	int mismatches = 0;
	int samples_checked = 0;
	logic [7:0] fc [4] = '{8'h5a, 8'h53, 8'h4a, 8'h5f};
	logic [1:0] mon [4] = '{2'h2, 2'h1, 2'h2, 2'h3};
	logic [2:0] fu [4] = '{3'b110, 3'b110, 3'b111, 3'b100};
	logic [31:0] t_ev [12] = '{32'h021312, 32'h020013, 32'h020012, 32'h000012, 32'h010012, 32'h010012,
		32'h040012, 32'h020012, 32'h080012, 32'h080012, 32'h100012, 32'h020012};
	logic [31:0] t_fn [12] = '{32'hf05a, 0, 32'h0077, 0, 0, 0, 0, 0, 0, 0, 0, 0};
	logic [3:0] t_cpu [12] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 4'h1, 4'h1, 4'h5, 4'h4, 4'ha, 4'h0};
	logic [31:0] t_ex [12] = '{32'h20003, 32'h2, 32'h4, 0, 32'h4, 0, 32'h4, 0, 32'h4, 0, 32'h4, 0};
	localparam logic [11:0] T_ON = 12'h7ff;

	always #20 CLK = ~CLK;

	cem_mcu_model mcu (.clk(CLK), .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY), .wdata(WDATA),
		.wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY), .bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
		.araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY), .rdata(RDATA), .rresp(RRESP),
		.rvalid(RVALID), .rready(RREADY));

	// Short microsecond divider keeps the time-base run brief
	cem_counters #(.US_CYCLES_P(5)) dut (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .INSTR_ISSUE(INSTR_ISSUE),
		.FUNC_CODE(FUNC_CODE), .MON_FIELD(MON_FIELD), .FU_NO_OUTPUT(FU_NO_OUTPUT),
		.FU_ALL_REQUESTED(FU_ALL_REQUESTED), .FU_SETUP_SHUTDOWN(FU_SETUP_SHUTDOWN), .CPU_LINES(CPU_LINES),
		.INSTR_BOUNDARY(INSTR_BOUNDARY), .FAULT_IN(FAULT_IN), .ENV_ALARM(ENV_ALARM), .MAINS_FAIL(MAINS_FAIL),
		.SECTION_FAIL(SECTION_FAIL), .CPU_HALT(CPU_HALT));

	// ----------------------------------------------------------------
	// Checks and access helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		samples_checked++;
		if ($isunknown(got) || got < lo || got > hi) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_rng

	task automatic w(input logic [7:0] a, input logic [31:0] v);
		mcu.wr(a, v, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : w

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		mcu.rd(a, d, r);
		chk(d, e);
	endtask : rc

	task automatic rg(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
		mcu.rd(a, d, r);
		chk_rng(d, lo, hi);
	endtask : rg

	task automatic halt_is(input logic e);
		repeat (3) @(posedge CLK);
		chk({31'h0, CPU_HALT}, {31'h0, e});
	endtask : halt_is

	// Four cycles of events: three masked function matches, two stalls, two monitor hits
	task automatic burst();
		for (int i = 0; i < 4; i++) begin
			@(posedge CLK);
			INSTR_ISSUE <= 1'b1;
			FUNC_CODE <= fc[i];
			MON_FIELD <= mon[i];
			{FU_NO_OUTPUT, FU_ALL_REQUESTED, FU_SETUP_SHUTDOWN} <= fu[i];
		end
		@(posedge CLK);
		INSTR_ISSUE <= 1'b0;
		MON_FIELD <= 2'h0;
		{FU_NO_OUTPUT, FU_ALL_REQUESTED, FU_SETUP_SHUTDOWN} <= 3'b000;
	endtask : burst

	// Count lines are dropped before every reselection so counters start clean
	task automatic trial(input int k);
		w(OFS_CTRL, 32'h0);
		w(OFS_EVSEL, t_ev[k]);
		w(OFS_FUNC, t_fn[k]);
		CPU_LINES <= cem_cpu_s'(t_cpu[k]);
		w(OFS_CTRL, {25'h0, T_ON[k], 6'h0});
		burst();
		w(OFS_CTRL, 32'h0);
		rc(OFS_DISP_A, t_ex[k]);
	endtask : trial

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (90000) @(posedge CLK);
		mismatches++;
		give_verdict();
	end

	initial begin
		CLK = 1'b0;
		RST_N = 1'b0;
		{INSTR_ISSUE, FUNC_CODE, MON_FIELD, FAULT_IN} = '0;
		{FU_NO_OUTPUT, FU_ALL_REQUESTED, FU_SETUP_SHUTDOWN} = 3'b000;
		{ENV_ALARM, MAINS_FAIL, SECTION_FAIL} = 3'b000;
		CPU_LINES = '0;
		INSTR_BOUNDARY = 1'b1;
		repeat (16) @(posedge CLK);
		RST_N <= 1'b1;
		rc(OFS_CTRL, 32'h0);
		rc(OFS_STATUS, 32'h0);
		mcu.rd(8'h1c, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		mcu.wr(8'h1c, 32'h0, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		{ENV_ALARM, MAINS_FAIL, SECTION_FAIL} <= 3'b111;
		rc(OFS_STATUS, 32'h700);
		{ENV_ALARM, MAINS_FAIL, SECTION_FAIL} <= 3'b100;
		rc(OFS_STATUS, 32'h100);
		{ENV_ALARM, MAINS_FAIL, SECTION_FAIL} <= 3'b000;
		for (int k = 0; k < 12; k++) trial(k);
		w(OFS_CTRL, 32'h8000);
		w(OFS_EVSEL, 32'h021200);
		w(OFS_CTRL, 32'h8080);
		repeat (100) @(posedge CLK);
		w(OFS_CTRL, 32'h8000);
		rg(OFS_DISP_B, 32'h130000, 32'h160000);
		rc(OFS_DISP_A, 32'h0);
		w(OFS_EVSEL, 32'h021313);
		w(OFS_CTRL, 32'h0);
		w(OFS_EVSEL, 32'h020013);
		MON_FIELD <= 2'h2;
		w(OFS_CTRL, 32'h10c0);
		repeat (30000) @(posedge CLK);
		// Stalls start late so the second B counter ends with its top bit high above a low remainder near 0x0ad2
		{FU_NO_OUTPUT, FU_ALL_REQUESTED, FU_SETUP_SHUTDOWN} <= 3'b110;
		repeat (35540) @(posedge CLK);
		w(OFS_CTRL, 32'h1000);
		MON_FIELD <= 2'h0;
		{FU_NO_OUTPUT, FU_ALL_REQUESTED, FU_SETUP_SHUTDOWN} <= 3'b000;
		rg(OFS_DISP_A, 32'h10002, 32'h10010);
		w(OFS_CTRL, 32'h1100);
		rg(OFS_DISP_B, 32'h8ad20002, 32'h8adc0010);
		rg(OFS_DISP_B, 32'h0ad20002, 32'h0adc0010);
		w(OFS_CTRL, 32'h0);
		w(OFS_EVSEL, 32'h020012);
		w(OFS_FUNC, 32'h0);
		w(OFS_CTRL, 32'h0240);
		@(posedge CLK);
		INSTR_ISSUE <= 1'b1;
		@(posedge CLK);
		INSTR_ISSUE <= 1'b0;
		halt_is(1'b1);
		rc(OFS_STATUS, 32'h18);
		w(OFS_CTRL, 32'h0);
		w(OFS_CMD, 32'h88);
		halt_is(1'b0);
		rc(OFS_DISP_A, 32'h1);
		for (int i = 0; i < 3; i++) begin
			@(posedge CLK);
			FAULT_IN <= 3'(1 << i);
			INSTR_BOUNDARY <= 1'b0;
			@(posedge CLK);
			FAULT_IN <= 3'h0;
			halt_is(1'b0);
			INSTR_BOUNDARY <= 1'b1;
			halt_is(1'b1);
			rc(OFS_STATUS, 32'(1 << i) | 32'h8);
			w(OFS_CMD, 32'h08);
			halt_is(1'b1);
			w(OFS_CMD, 32'h80);
			w(OFS_CMD, 32'h08);
			halt_is(1'b0);
			rc(OFS_STATUS, 32'h0);
		end
		give_verdict();
	end
endmodule : cem_counters_tb_top
